// ===== logic/scx_core_tick.sv
// Synchronous core clock enable generator with selectable input clock divisor.
`timescale 1ns/1ps
module scx_core_tick (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // Divisor code
    input  wire logic [2:0] div_sel,
    // Core clock enable
    output logic            tick
);

    typedef struct packed {
        logic [3:0] acc;
        logic       tick;
    } sct_st_s;

    sct_st_s    st;
    sct_st_s    next_st;
    logic [3:0] half;
    logic [3:0] sum;

    // ****************************************
    // Fractional divider
    // ****************************************
    // Counting in half clocks lets the 1.5 divisor come out as two ticks in three clocks.
    always_comb begin
        next_st = st;
        case (div_sel)
            3'h0: half = scx_pkg::DIV_H0;
            3'h1: half = scx_pkg::DIV_H1;
            3'h2: half = scx_pkg::DIV_H2;
            3'h3: half = scx_pkg::DIV_H3;
            3'h4: half = scx_pkg::DIV_H4;
            default: half = 4'h0;
        endcase
        sum = st.acc + scx_pkg::DIV_STEP;
        next_st.tick = 1'b0;
        if (half == 4'h0) begin // RQ14
            next_st.acc = 4'h0;
        end else if (sum >= half) begin // RQ14
            next_st.acc  = sum - half;
            next_st.tick = 1'b1;
        end else begin
            next_st.acc = sum;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_div_reserved: assert property (div_sel > scx_pkg::DIV_MAX |=> !tick) // RQ14
        else $error("core tick from reserved divisor code");
    a_div_unity: assert property ((div_sel == 3'h1) [*2] |=> tick) // RQ14
        else $error("divide by one does not tick every clock");

endmodule

// ===== logic/scx_idcfg.sv
// Own bus ID, response enables, arbitration and synchronous transfer pacing.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
// Function
// RQ1 - Reselection answered only when its enable set
// RQ2 - Reselection never changes the operating role
// RQ3 - Selection answered only when its enable set
// RQ4 - Selection never changes the operating role
// RQ5 - Own ID field driven during arbitration
// RQ6 - Priority 7 down to 0, then 15 to 8
// RQ7 - Period code gives code plus four clocks
// RQ8 - Software picks period from rate and clock
// RQ9 - Extra setup clock only when sending
// RQ10 - Core clock is input clock over divisor
// RQ11 - Table load writes whole transfer register
// RQ12 - Offset 0 async, 1 to 16, rest reserved
// RQ13 - Synchronous only in data phases
// RQ14 - Divisor codes 3, 1, 1.5, 2, 3
// RQ15 - Stall while outstanding equals maximum offset
module scx_idcfg (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // Register port
    input  wire scx_pkg::scx_bus_s bus,
    output logic [7:0]            rdata,
    // Bus pins, active low in
    input  wire scx_pkg::scx_pin_s pin_n,
    output scx_pkg::scx_pout_s    pin_o,
    // Script processor table load
    input  wire logic             tbl_load,
    input  wire logic [7:0]       tbl_data,
    // Transfer user side
    input  wire logic             xfer_valid,
    output logic                  xfer_taken,
    // Status
    output logic                  role_target,
    output logic                  sync_active
);

    typedef struct packed {
        scx_pkg::scx_pin_s  meta;
        scx_pkg::scx_pin_s  sync;
        logic               stb_prev;
        logic [7:0]         ctl1;
        logic [7:0]         ccr3;
        logic [7:0]         own;
        logic [7:0]         sxf;
        logic [7:0]         ridl;
        logic [7:0]         ridh;
        logic [4:0]         stat;
        logic [7:0]         rdata;
        scx_pkg::scx_arb_e  arb;
        logic [4:0]         arb_cnt;
        scx_pkg::scx_xf_e   xf;
        logic [3:0]         tcnt;
        logic [4:0]         outst;
        logic               smode;
        logic               taken;
        scx_pkg::scx_pout_s po;
    } scx_st_s;

    scx_st_s     st;
    scx_st_s     next_st;
    logic        tick;
    logic [15:0] rid;
    logic        sel_hit;
    logic        set_sel;
    logic        set_resel;
    logic        dphase;
    logic        bad_ofs;
    logic        sync_mode;
    logic        stb_rise;
    logic        inc;
    logic        dec;
    logic        room;
    logic [3:0]  per;
    logic [3:0]  hi;
    logic [3:0]  lo;
    logic [4:0]  set_st;
    logic [4:0]  clr_st;

    // ****************************************
    // Helper functions
    // ****************************************
    function automatic logic [3:0] id_rank(input logic [3:0] id);
        id_rank = id[3] ? {1'b0, id[2:0]} : {1'b1, id[2:0]};
    endfunction

    function automatic logic higher_seen(input logic [15:0] data, input logic [3:0] id);
        logic hit;
        hit = 1'b0;
        for (int j = 0; j < 16; j++) begin
            if (data[j] && id_rank(4'(j)) > id_rank(id)) begin // RQ6
                hit = 1'b1;
            end
        end
        higher_seen = hit;
    endfunction

    function automatic logic [3:0] period_of(input logic [2:0] code, input logic ext);
        period_of = scx_pkg::PERIOD_BASE + {1'b0, code} + {3'h0, ext}; // RQ7
    endfunction

    // ****************************************
    // Core clock enable
    // ****************************************
    scx_core_tick u_tick (
        .clk     (clk),
        .arst_n  (arst_n),
        .div_sel (st.ccr3[scx_pkg::SCF_LSB +: 3]), // RQ10
        .tick    (tick)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_st          = st;
        next_st.meta     = scx_pkg::scx_pin_s'(~pin_n);
        next_st.sync     = st.meta;
        next_st.stb_prev = st.sync.stb;
        next_st.taken    = 1'b0;
        next_st.rdata    = 8'h00;
        clr_st           = 5'h00;

        if (bus.wr) begin
            case (bus.addr)
                scx_pkg::A_CTL1: next_st.ctl1 = bus.wdata;
                scx_pkg::A_CCR3: next_st.ccr3 = bus.wdata & scx_pkg::CCR3_MASK;
                scx_pkg::A_OWN:  next_st.own  = bus.wdata & scx_pkg::OWN_MASK;
                scx_pkg::A_SXF:  next_st.sxf  = bus.wdata;
                scx_pkg::A_RIDL: next_st.ridl = bus.wdata;
                scx_pkg::A_RIDH: next_st.ridh = bus.wdata;
                scx_pkg::A_STAT: clr_st       = bus.wdata[4:0];
                default: ;
            endcase
        end
        // The script processor's load lands after a same-cycle software write.
        if (tbl_load) begin
            next_st.sxf = tbl_data; // RQ11
        end

        // Selection and reselection response; role bits are untouched here.
        rid       = {st.ridh, st.ridl};
        sel_hit   = st.sync.sel && !st.sync.bsy && |(rid & st.sync.data)
                    && st.arb == scx_pkg::ARB_IDLE && !st.po.bsy_oe;
        set_sel   = sel_hit && !st.sync.io && st.own[scx_pkg::OWN_SRE]; // RQ3
        set_resel = sel_hit && st.sync.io && st.own[scx_pkg::OWN_RRE]; // RQ1

        // Offset decode and transfer mode.
        dphase    = !st.sync.msg && !st.sync.cd;
        bad_ofs   = st.sxf[4] && |st.sxf[3:0]; // RQ12
        // A reserved divisor never ticks, so pacing falls back to the handshake.
        sync_mode = dphase && st.sxf[4:0] != 5'h00 && !bad_ofs // RQ13
                    && st.ccr3[scx_pkg::SCF_LSB +: 3] <= scx_pkg::DIV_MAX; // RQ14
        next_st.smode = sync_mode;
        per = period_of(st.sxf[7:5], st.ctl1[scx_pkg::C1_EXT] && st.ctl1[scx_pkg::C1_SEND]); // RQ9
        hi  = {1'b0, per[3:1]};
        lo  = per - hi;

        set_st = 5'h00;
        set_st[scx_pkg::ST_SEL]   = set_sel;
        set_st[scx_pkg::ST_RESEL] = set_resel;
        set_st[scx_pkg::ST_BAD]   = xfer_valid && dphase
                                    && (bad_ofs || st.ccr3[6:4] > scx_pkg::DIV_MAX);

        // Arbitration.
        case (st.arb)
            scx_pkg::ARB_IDLE: begin
                if (st.ctl1[scx_pkg::C1_ARB] && !st.po.bsy_oe) begin
                    next_st.arb = scx_pkg::ARB_WAIT;
                end
            end
            scx_pkg::ARB_WAIT: begin
                if (!st.ctl1[scx_pkg::C1_ARB]) begin
                    next_st.arb = scx_pkg::ARB_IDLE;
                end else if (!st.sync.bsy && !st.sync.sel) begin
                    next_st.arb     = scx_pkg::ARB_RUN;
                    next_st.arb_cnt = scx_pkg::ARB_CYC;
                end
            end
            scx_pkg::ARB_RUN: begin
                if (st.arb_cnt != 5'h01) begin
                    next_st.arb_cnt = st.arb_cnt - 5'h01;
                end else if (higher_seen(st.sync.data, st.own[3:0])) begin // RQ6
                    // A lost round clears the request so the bus is not hammered.
                    next_st.arb = scx_pkg::ARB_IDLE;
                    next_st.ctl1[scx_pkg::C1_ARB] = 1'b0;
                    set_st[scx_pkg::ST_LOST] = 1'b1;
                end else begin
                    next_st.arb = scx_pkg::ARB_HOLD;
                    set_st[scx_pkg::ST_WON] = 1'b1;
                end
            end
            scx_pkg::ARB_HOLD: begin
                if (!st.ctl1[scx_pkg::C1_ARB]) begin
                    next_st.arb = scx_pkg::ARB_IDLE;
                end
            end
            default: next_st.arb = scx_pkg::ARB_IDLE;
        endcase

        // Sticky status: a set in the clearing cycle survives.
        next_st.stat = (st.stat & ~clr_st) | set_st;

        // Transfer pacing.
        stb_rise = st.sync.stb && !st.stb_prev;
        room     = st.outst < st.sxf[4:0]; // RQ15
        inc      = 1'b0;
        dec      = stb_rise && st.outst != 5'h00;
        case (st.xf)
            scx_pkg::XF_IDLE: begin
                if (xfer_valid && (sync_mode ? room : !st.sync.stb)) begin // RQ15
                    next_st.xf    = scx_pkg::XF_ON;
                    next_st.tcnt  = hi;
                    next_st.taken = 1'b1;
                    inc           = sync_mode;
                end
            end
            scx_pkg::XF_ON: begin
                if (!st.smode) begin
                    if (st.sync.stb) begin
                        next_st.xf = scx_pkg::XF_OFF;
                    end
                end else if (tick) begin // RQ7
                    if (st.tcnt <= 4'h1) begin
                        next_st.xf   = scx_pkg::XF_OFF;
                        next_st.tcnt = lo;
                    end else begin
                        next_st.tcnt = st.tcnt - 4'h1;
                    end
                end
            end
            scx_pkg::XF_OFF: begin
                if (!st.smode) begin
                    if (!st.sync.stb) begin
                        next_st.xf = scx_pkg::XF_IDLE;
                    end
                end else if (tick) begin // RQ7
                    if (st.tcnt <= 4'h1) begin
                        next_st.xf = scx_pkg::XF_IDLE;
                    end else begin
                        next_st.tcnt = st.tcnt - 4'h1;
                    end
                end
            end
            default: next_st.xf = scx_pkg::XF_IDLE;
        endcase
        next_st.outst = st.outst + {4'h0, inc} - {4'h0, dec};

        // Pin drive: open drain, so only the enables move.
        next_st.po         = '0;
        next_st.po.data_oe = (next_st.arb == scx_pkg::ARB_RUN)
                             ? 16'h0001 << next_st.own[3:0] : 16'h0000; // RQ5
        next_st.po.bsy_oe  = next_st.arb == scx_pkg::ARB_RUN
                             || next_st.arb == scx_pkg::ARB_HOLD
                             || next_st.stat[scx_pkg::ST_SEL]
                             || next_st.stat[scx_pkg::ST_RESEL];
        next_st.po.sel_oe  = next_st.arb == scx_pkg::ARB_HOLD;
        next_st.po.stb_oe  = next_st.xf == scx_pkg::XF_ON;

        if (bus.rd) begin
            case (bus.addr)
                scx_pkg::A_CTL1: next_st.rdata = st.ctl1;
                scx_pkg::A_CCR3: next_st.rdata = st.ccr3;
                scx_pkg::A_OWN:  next_st.rdata = st.own;
                scx_pkg::A_SXF:  next_st.rdata = st.sxf;
                scx_pkg::A_RIDL: next_st.rdata = st.ridl;
                scx_pkg::A_RIDH: next_st.rdata = st.ridh;
                scx_pkg::A_STAT: next_st.rdata = {st.smode, st.outst != 5'h00,
                                                  st.arb != scx_pkg::ARB_IDLE, st.stat};
                default: next_st.rdata = 8'h00;
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rdata       = st.rdata;
    assign pin_o       = st.po;
    assign xfer_taken  = st.taken;
    assign role_target = st.ctl1[scx_pkg::C1_TGT]; // RQ2 RQ4
    assign sync_active = st.smode;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_sel_seen;
        sel_hit && !st.sync.io && st.own[scx_pkg::OWN_SRE];
    endsequence
    sequence s_bsy_answer;
        st.stat[scx_pkg::ST_SEL] && pin_o.bsy_oe;
    endsequence

    a_sel_answer: assert property (s_sel_seen |=> s_bsy_answer) // RQ3
        else $error("enabled selection not answered with busy");
    a_sel_gate: assert property (sel_hit && !st.sync.io && !st.own[scx_pkg::OWN_SRE]
                                 && !st.stat[scx_pkg::ST_SEL] && !(bus.wr) |=> !st.stat[scx_pkg::ST_SEL]) // RQ3
        else $error("selection answered while disabled");
    a_resel_gate: assert property (sel_hit && st.sync.io && !st.own[scx_pkg::OWN_RRE]
                                   && !st.stat[scx_pkg::ST_RESEL] |=> !st.stat[scx_pkg::ST_RESEL]) // RQ1
        else $error("reselection answered while disabled");
    a_role_hold: assert property ($changed(role_target) |-> $past(bus.wr)
                                  && $past(bus.addr) == scx_pkg::A_CTL1) // RQ2 RQ4
        else $error("role changed without a software write");
    a_own_id: assert property (st.arb == scx_pkg::ARB_RUN
                               |-> pin_o.data_oe == 16'h0001 << st.own[3:0]) // RQ5
        else $error("own ID not driven during arbitration");
    a_arb_rank: assert property (st.arb == scx_pkg::ARB_RUN && st.arb_cnt == 5'h01
                                 && st.ctl1[scx_pkg::C1_ARB] && higher_seen(st.sync.data, st.own[3:0])
                                 |=> st.stat[scx_pkg::ST_LOST] && !pin_o.bsy_oe[*1]) // RQ6
        else $error("arbitration not lost to higher ID");
    a_tbl_load: assert property (tbl_load |=> st.sxf == $past(tbl_data)) // RQ11
        else $error("table load did not set transfer register");
    a_offset_cap: assert property (st.smode |-> st.outst <= st.sxf[4:0]) // RQ15 RQ12
        else $error("outstanding count passed maximum offset");
    a_async_other: assert property (st.sync.msg || st.sync.cd |=> !sync_active) // RQ13
        else $error("synchronous mode outside data phase");
    a_full_stall: assert property (st.xf == scx_pkg::XF_IDLE && st.smode && sync_mode
                                   && st.outst == st.sxf[4:0] |=> !xfer_taken) // RQ15
        else $error("transfer issued with offset exhausted");

endmodule

// ===== logic/scx_pkg.sv
// Shared constants, carriers and state enumerations of the bus ID and sync transfer block.
package scx_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] A_CTL1 = 8'h01;
    localparam logic [7:0] A_CCR3 = 8'h03;
    localparam logic [7:0] A_OWN  = 8'h04;
    localparam logic [7:0] A_SXF  = 8'h05;
    localparam logic [7:0] A_RIDL = 8'h40;
    localparam logic [7:0] A_RIDH = 8'h41;
    localparam logic [7:0] A_STAT = 8'h42;

    // ****************************************
    // Field positions, masks and reset values
    // ****************************************
    localparam int         C1_SEND   = 0;
    localparam int         C1_TGT    = 1;
    localparam int         C1_ARB    = 2;
    localparam int         C1_EXT    = 7;
    localparam int         OWN_SRE   = 5;
    localparam int         OWN_RRE   = 6;
    localparam int         SCF_LSB   = 4;
    localparam int         ST_SEL    = 0;
    localparam int         ST_RESEL  = 1;
    localparam int         ST_WON    = 2;
    localparam int         ST_LOST   = 3;
    localparam int         ST_BAD    = 4;
    localparam logic [7:0] OWN_MASK  = 8'h6F;
    localparam logic [7:0] CCR3_MASK = 8'h7F;
    localparam logic [7:0] RST_REG   = 8'h00;

    // ****************************************
    // Timing and code tables
    // ****************************************
    localparam int         CLK_NS      = 100;
    localparam int         ARB_NS      = 2400;
    localparam logic [4:0] ARB_CYC     = 5'((ARB_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] PERIOD_BASE = 4'h4;
    localparam logic [4:0] OFS_MAX     = 5'h10;
    localparam logic [2:0] DIV_MAX     = 3'h4;
    // Divide factors in half clocks: 3, 1, 1.5, 2, 3.
    localparam logic [3:0] DIV_H0      = 4'h6;
    localparam logic [3:0] DIV_H1      = 4'h2;
    localparam logic [3:0] DIV_H2      = 4'h3;
    localparam logic [3:0] DIV_H3      = 4'h4;
    localparam logic [3:0] DIV_H4      = 4'h6;
    localparam logic [3:0] DIV_STEP    = 4'h2;

    // ****************************************
    // Carriers and states
    // ****************************************
    typedef struct packed {
        logic        sel;
        logic        bsy;
        logic        io;
        logic        cd;
        logic        msg;
        logic        stb;
        logic [15:0] data;
    } scx_pin_s;

    typedef struct packed {
        logic        sel_o;
        logic        sel_oe;
        logic        bsy_o;
        logic        bsy_oe;
        logic        stb_o;
        logic        stb_oe;
        logic [15:0] data_o;
        logic [15:0] data_oe;
    } scx_pout_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } scx_bus_s;

    typedef enum logic [1:0] {
        ARB_IDLE = 2'b00,
        ARB_WAIT = 2'b01,
        ARB_RUN  = 2'b11,
        ARB_HOLD = 2'b10
    } scx_arb_e;

    typedef enum logic [1:0] {
        XF_IDLE = 2'b00,
        XF_ON   = 2'b01,
        XF_OFF  = 2'b11
    } scx_xf_e;

endpackage

// ===== sim/scx_peer.sv
// Model of another bus device that shares the open-drain lines with the block.
`timescale 1ns/1ps
module scx_peer (
    // Clock
    input  wire logic               clk,
    // Device pins, peer requests and a forced acknowledge
    input  wire scx_pkg::scx_pout_s pin_o,
    input  wire scx_pkg::scx_pin_s  drv,
    input  wire logic               ack_force,
    // Resolved lines, active low
    output wire scx_pkg::scx_pin_s  pin_n
);
    // ********************************
    // Acknowledge and line resolution
    // ********************************
    logic [2:0] req_sh = 3'h0;

    // Acknowledge trails each strobe by three clocks; drv.stb low withholds it.
    always_ff @(posedge clk) begin
        req_sh <= {req_sh[1:0], pin_o.stb_oe};
    end

    // Lines are terminated, so a released line reads high, never a stale value.
    assign pin_n.sel  = ~(pin_o.sel_oe | drv.sel);
    assign pin_n.bsy  = ~(pin_o.bsy_oe | drv.bsy);
    assign pin_n.io   = ~drv.io;
    assign pin_n.cd   = ~drv.cd;
    assign pin_n.msg  = ~drv.msg;
    assign pin_n.stb  = ~((drv.stb & req_sh[2]) | ack_force);
    assign pin_n.data = ~(pin_o.data_oe | drv.data);
endmodule

// ===== sim/tb.sv
// Self-checking bench of the bus ID and sync transfer block.
`timescale 1ns/1ps
module tb;
    logic               clk;
    logic               arst_n;
    logic               tbl_load;
    logic               xfer_valid;
    logic               xfer_taken;
    logic               role_target;
    logic               sync_active;
    logic               ack_force;
    logic [7:0]         tbl_data;
    logic [7:0]         rdata;
    logic [7:0]         v;
    logic [7:0]         r;
    logic [7:0]         cfg [8];
    logic [2:0]         dv;
    scx_pkg::scx_bus_s  bus;
    scx_pkg::scx_pin_s  drv;
    scx_pkg::scx_pin_s  pin_n;
    scx_pkg::scx_pout_s pin_o;
    int                 errors;
    int                 cmp_count;
    int                 n;
    int                 k;
    int                 e;

    scx_idcfg u_scx_idcfg (.clk(clk), .arst_n(arst_n), .bus(bus), .rdata(rdata),
        .pin_n(pin_n), .pin_o(pin_o), .tbl_load(tbl_load), .tbl_data(tbl_data),
        .xfer_valid(xfer_valid), .xfer_taken(xfer_taken), .role_target(role_target),
        .sync_active(sync_active));
    scx_peer u_scx_peer (.clk(clk), .pin_o(pin_o), .drv(drv), .ack_force(ack_force),
        .pin_n(pin_n));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ****************
    // Helpers
    // ****************
    function automatic int rank(input int id);
        return (id < 8) ? id + 8 : id - 8;
    endfunction

    // Core clock period in half input clocks.
    function automatic int half(input logic [2:0] d);
        return (d == 3'h1) ? 2 : (d == 3'h2) ? 3 : (d == 3'h3) ? 4 : 6;
    endfunction

    task automatic finish_test();
        $display("Comparisons %0d, errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
        cmp_count++;
        if (g !== x) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
        cmp_count++;
        if (g < lo || g > hi) begin
            errors++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= {a, d, 2'b10};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        bus <= {a, 8'h00, 2'b01};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask

    // Selector 1 waits for the strobe, 0 for the busy drive.
    task automatic wait_for(input int s);
        for (int i = 0; i < 200; i++) begin
            @(posedge clk);
            #1;
            if (s ? pin_o.stb_oe === 1'b1 : pin_o.bsy_oe === 1'b1) return;
        end
        errors++;
        finish_test();
    endtask

    initial begin
        #5_000_000;
        errors++;
        finish_test();
    end

    // ****************
    // Main sequence
    // ****************
    initial begin
        cfg = '{8'h20, 8'h27, 8'h26, 8'h3F, 8'h6D, 8'h10, 8'h80, 8'h49};
        errors = 0;
        cmp_count = 0;
        arst_n = 1'b0;
        bus = '0;
        drv = '0;
        drv.stb = 1'b1;
        tbl_load = 1'b0;
        tbl_data = 8'h00;
        xfer_valid = 1'b0;
        ack_force = 1'b0;
        void'($urandom(97));
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        rd(scx_pkg::A_SXF, r);
        chk("sxf reset", scx_pkg::RST_REG, r);
        @(posedge clk);
        #1 chk("rdata idle", 0, rdata);
        for (k = 0; k < 4; k++) begin
            v = $urandom;
            wr(scx_pkg::A_OWN, v);
            wr(8'h9C, v);
            rd(scx_pkg::A_OWN, r);
            chk("own", v & scx_pkg::OWN_MASK, r);
            rd(8'h9C, r);
            chk("unmapped", 0, r);
        end
        v = $urandom;
        @(posedge clk);
        tbl_load <= 1'b1;
        tbl_data <= v;
        bus <= {scx_pkg::A_SXF, ~v, 2'b10};
        @(posedge clk);
        tbl_load <= 1'b0;
        bus.wr <= 1'b0;
        rd(scx_pkg::A_SXF, r);
        chk("table load", v, r);
        wr(scx_pkg::A_SXF, 8'h00);
        wr(scx_pkg::A_RIDL, 8'h08);
        for (k = 0; k < 4; k++) begin
            wr(scx_pkg::A_OWN, {1'b0, k[1] ~^ k[0], k[1] ^ k[0], 5'h00});
            wr(scx_pkg::A_CTL1, {6'h00, k[0], 1'b0});
            drv.sel <= 1'b1;
            drv.io <= k[1];
            drv.data <= 16'h0088;
            repeat (6) @(posedge clk);
            #1 chk("sel busy", k[0], pin_o.bsy_oe);
            chk("role", k[0], role_target);
            rd(scx_pkg::A_STAT, r);
            chk("sel status", k[0] ? (k[1] ? 2 : 1) : 0, r[1:0]);
            drv.sel <= 1'b0;
            drv.data <= '0;
            wr(scx_pkg::A_STAT, 8'h1F);
        end
        for (k = 0; k < 3; k++) begin
            n = (k == 0) ? 0 : (k == 1) ? 15 : $urandom_range(15);
            e = (k == 0) ? 8 : (k == 1) ? 7 : (n + 1 + $urandom_range(14)) % 16;
            wr(scx_pkg::A_OWN, 8'(n));
            drv.data <= 16'h1 << e;
            wr(scx_pkg::A_CTL1, 8'h04);
            wait_for(0);
            chk("arb id", 16'h1 << n, pin_o.data_oe);
            repeat (40) @(posedge clk);
            #1 chk("arb won", rank(n) > rank(e), pin_o.sel_oe);
            rd(scx_pkg::A_STAT, r);
            chk("arb status", rank(n) > rank(e) ? 1 : 2, r[3:2]);
            drv.data <= '0;
            wr(scx_pkg::A_CTL1, 8'h00);
            wr(scx_pkg::A_STAT, 8'h1F);
        end
        // Each entry: divisor, period code, extra setup, sending.
        for (k = 0; k < 8; k++) begin
            v = cfg[k];
            wr(scx_pkg::A_CCR3, {1'b0, v[7:5], 4'h0});
            wr(scx_pkg::A_CTL1, {v[1], 6'h00, v[0]});
            wr(scx_pkg::A_SXF, {v[4:2], 5'h10});
            e = (32'(v[4:2]) + 4 + 32'(v[1] & v[0])) / 2 * half(v[7:5]) / 2;
            @(posedge clk);
            #1 chk("sync on", 1, sync_active);
            xfer_valid <= 1'b1;
            wait_for(1);
            xfer_valid <= 1'b0;
            for (n = 1; n < 99 && pin_o.stb_oe === 1'b1; n++) begin
                @(posedge clk);
                #1;
            end
            n = n - 1;
            chk_rng("strobe", e - (half(v[7:5]) - 1) / 2, e + (half(v[7:5]) - 1) / 2, n);
            repeat (30) @(posedge clk);
        end
        for (k = 0; k < 2; k++) begin
            drv.cd <= ~k[0];
            drv.msg <= k[0];
            repeat (4) @(posedge clk);
            #1 chk("phase", 0, sync_active);
        end
        drv.msg <= 1'b0;
        for (k = 0; k < 12; k++) begin
            dv = (k < 3) ? 3'(k + 5) : 3'($urandom);
            v = (k < 3) ? 8'h10 : (k == 3) ? 8'h00 : (k == 4) ? 8'h11 : 8'($urandom);
            e = (dv > 3'h4 || v[4:0] > 5'h10) ? 1 : 0;
            wr(scx_pkg::A_CCR3, {1'b0, dv, 4'h0});
            wr(scx_pkg::A_SXF, v);
            xfer_valid <= 1'b1;
            repeat (3) @(posedge clk);
            #1 chk("sync mode", e == 0 && v[4:0] != 5'h00, sync_active);
            xfer_valid <= 1'b0;
            rd(scx_pkg::A_STAT, r);
            chk("bad config", e, r[4]);
            wr(scx_pkg::A_CCR3, 8'h10);
            wr(scx_pkg::A_SXF, 8'h00);
            wr(scx_pkg::A_STAT, 8'h1F);
        end
        drv.stb <= 1'b0;
        xfer_valid <= 1'b1;
        wait_for(1);
        xfer_valid <= 1'b0;
        repeat (30) @(posedge clk);
        #1 chk("async hold", 1, pin_o.stb_oe);
        drv.stb <= 1'b1;
        repeat (10) @(posedge clk);
        #1 chk("async drop", 0, pin_o.stb_oe);
        wr(scx_pkg::A_SXF, 8'h02);
        drv.stb <= 1'b0;
        xfer_valid <= 1'b1;
        n = 0;
        for (k = 0; k < 80; k++) begin
            @(posedge clk);
            ack_force <= (k >= 40 && k < 44);
            #1 n += xfer_taken;
            if (k == 39) chk_rng("stall", 2, 2, n);
        end
        chk_rng("resume", 3, 3, n);
        finish_test();
    end
endmodule
